/* File: video_pixel_input_port.sv */
`timescale 1ns/10ps
`include "pixel_port_cfg.svh"
module video_pixel_input_port
	import pixel_port_pkg::*;
#(
	parameter bit NARROW_BUS = 1'b0,
	parameter bit SD_ONLY_PACKAGE = 1'b0
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [15:0] pixelBus,
	input wire logic hsync_n,
	input wire logic vsync_n,
	input wire logic [2:0] inputModeWrite,
	input wire logic inputModeLoad,
	input wire logic [1:0] ddrEdgeSelect,
	input wire logic [1:0] sdBusWidthSelect,
	input wire logic rgbCaptureSelect,
	input wire logic embeddedTimingSelect,
	output logic [2:0] inputMode,
	output logic formatReserved,
	output logic overflow,
	output logic pixelValid,
	input wire logic pixelReady,
	output pixel_word_t pixelWord
);
	cap_regs_t r_reg;
	cap_regs_t r_next;
	logic [2:0] mode_reg;
	logic [2:0] mode_next;
	logic overflow_reg;
	logic fifoReady;
	logic [15:0] fallBus_reg;
	logic fallHs_reg;
	logic fallVs_reg;
	logic [15:0] busNow;
	logic hsNow;
	logic vsNow;
	logic ddrMode;
	logic ed54Mode;
	logic modeLegal;
	logic lumaOnFall;
	logic wideFmt;
	logic useEmbedded;
	logic [9:0] laneValue;
	logic codeByte;

	// Input mode reset to SD, reloaded by software
	// R2 power-up default
	always_comb begin
		modeLegal = (inputModeWrite == `MODE_SD) || (inputModeWrite == `MODE_DDR)
			|| (inputModeWrite == `MODE_ED54);
		mode_next = mode_reg;
		// R14 SD-only package
		if (inputModeLoad && modeLegal && !(SD_ONLY_PACKAGE && inputModeWrite != `MODE_SD)) begin
			mode_next = inputModeWrite;
		end
	end

	// Falling-edge capture used only by DDR mode
	always_ff @(negedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fallBus_reg <= 16'h0000;
			fallHs_reg <= 1'b1;
			fallVs_reg <= 1'b1;
		end else begin
			fallBus_reg <= pixelBus;
			fallHs_reg <= hsync_n;
			fallVs_reg <= vsync_n;
		end
	end

	always_comb begin
		// R1 mode decode
		ddrMode = (mode_reg == `MODE_DDR);
		ed54Mode = (mode_reg == `MODE_ED54);
		// R6 luma edge select
		lumaOnFall = (ddrEdgeSelect == `EDGE_LUMA_FALL);
		wideFmt = !NARROW_BUS && (mode_reg == `MODE_SD)
			&& (rgbCaptureSelect || sdBusWidthSelect == `WIDTH_16);
		// R7 R13 R4 timing source
		useEmbedded = ed54Mode || (embeddedTimingSelect && !wideFmt);
		// R16 single-edge capture on rising edge
		busNow = pixelBus;
		hsNow = hsync_n;
		vsNow = vsync_n;
		// R5 luma and chroma phases both taken from the falling edge when luma is on fall
		if (ddrMode && lumaOnFall) begin
			busNow = fallBus_reg;
			hsNow = fallHs_reg;
			vsNow = fallVs_reg;
		end
		laneValue = 10'h000;
		// R3 narrow bus on lines 7..0
		if (NARROW_BUS) begin
			laneValue = {busNow[7:0], 2'h0};
		// R10 ten-bit lane, line 6 LSB
		end else if ((mode_reg == `MODE_SD && sdBusWidthSelect == `WIDTH_10) || !(mode_reg == `MODE_SD)) begin
			laneValue = busNow[15:6];
		// R9 eight-bit upper lines
		end else begin
			laneValue = {busNow[15:8], 2'h0};
		end
		codeByte = (laneValue[9:2] == 8'hff) || (laneValue[9:2] == 8'h00);
	end

	always_comb begin
		r_next = r_reg;
		r_next.pushValid = 1'b0;
		// R15 reserved width captures nothing
		if (mode_reg == `MODE_SD && sdBusWidthSelect == `WIDTH_RSVD && !NARROW_BUS && !rgbCaptureSelect) begin
			r_next.state = ST_IDLE;
		end else if (!fifoReady) begin
			r_next.state = r_reg.state;
		end else begin
			case (r_reg.state)
				ST_IDLE: begin
					r_next.state = wideFmt ? ST_HOLD : ST_FIRST;
				end
				ST_FIRST: begin
					r_next.firstByte = laneValue;
					r_next.state = ST_SECOND;
				end
				ST_SECOND: begin
					r_next.word = '0;
					r_next.word.luma = r_reg.firstByte;
					r_next.word.chroma = laneValue;
					r_next.word.hsync = useEmbedded ? 1'b1 : hsNow;
					r_next.word.vsync = useEmbedded ? 1'b1 : vsNow;
					r_next.word.timingEmbedded = useEmbedded;
					r_next.word.codeSeen = useEmbedded && (r_reg.codeRun == 3'h3);
					r_next.pushValid = 1'b1;
					r_next.state = wideFmt ? ST_HOLD : ST_FIRST;
				end
				ST_HOLD: begin
					// R11 R12 wide words every second clock
					r_next.word = '0;
					r_next.word.isRgb = rgbCaptureSelect;
					if (rgbCaptureSelect) begin
						r_next.word.red = busNow[4:0];
						r_next.word.green = busNow[10:5];
						r_next.word.blue = busNow[15:11];
					end else begin
						r_next.word.luma = {busNow[15:8], 2'h0};
						r_next.word.chroma = {busNow[7:0], 2'h0};
					end
					r_next.word.hsync = hsNow;
					r_next.word.vsync = vsNow;
					r_next.pushValid = 1'b1;
					r_next.state = ST_SECOND;
				end
				default: begin
					r_next.state = ST_IDLE;
				end
			endcase
			if (r_reg.state == ST_SECOND && wideFmt) begin
				r_next.pushValid = 1'b0;
			end
		end
		// Embedded code detection
		if (codeByte && r_reg.codeRun != 3'h7) begin
			r_next.codeRun = r_reg.codeRun + 3'h1;
		end else if (!codeByte) begin
			r_next.codeRun = 3'h0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= '{state: ST_IDLE, firstByte: 10'h000, codeRun: 3'h0, pushValid: 1'b0,
				word: '0};
			mode_reg <= `MODE_RESET;
			overflow_reg <= 1'b0;
		end else begin
			r_reg <= r_next;
			mode_reg <= mode_next;
			overflow_reg <= r_reg.pushValid && !fifoReady;
		end
	end

	pixel_fifo #(
		.WIDTH($bits(pixel_word_t)),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.inValid(r_reg.pushValid),
		.inReady(fifoReady),
		.inData(r_reg.word),
		.outValid(pixelValid),
		.outReady(pixelReady),
		.outData(pixelWord)
	);

	assign inputMode = mode_reg;
	assign formatReserved = (sdBusWidthSelect == `WIDTH_RSVD);
	assign overflow = overflow_reg;

	// R2 mode holds without a load
	chk_mode_hold: assert property (@(posedge clock) disable iff (!reset_n) // R2
		!inputModeLoad |=> $stable(mode_reg)) else $error("Mode changed without load");
	// R14 package restricted
	chk_sd_only: assert property (@(posedge clock) disable iff (!reset_n) // R14
		SD_ONLY_PACKAGE |-> mode_reg == `MODE_SD) else $error("Non-SD mode on SD package");
	// R1 legal mode values
	chk_mode_legal: assert property (@(posedge clock) disable iff (!reset_n) // R1
		mode_reg inside {`MODE_SD, `MODE_DDR, `MODE_ED54}) else $error("Illegal mode");
	// R7 external sync ignored
	chk_ed54_sync: assert property (@(posedge clock) disable iff (!reset_n) // R7
		r_reg.pushValid && ed54Mode && $past(ed54Mode) |-> r_reg.word.timingEmbedded)
		else $error("External sync used at 54 MHz");
	// R13 wide formats use external sync
	chk_wide_sync: assert property (@(posedge clock) disable iff (!reset_n) // R13
		r_reg.pushValid && wideFmt && $past(wideFmt) |-> !r_reg.word.timingEmbedded)
		else $error("Embedded timing in wide format");
	// R15 reserved width pushes nothing
	chk_rsvd_none: assert property (@(posedge clock) disable iff (!reset_n) // R15
		(mode_reg == `MODE_SD && sdBusWidthSelect == `WIDTH_RSVD && !NARROW_BUS
		&& !rgbCaptureSelect) |=> r_reg.state == ST_IDLE) else $error("Reserved width captured");
	// R12 RGB lanes
	sequence rgbCapture;
		wideFmt && rgbCaptureSelect && fifoReady && r_reg.state == ST_HOLD;
	endsequence
	chk_rgb_lanes: assert property (@(posedge clock) disable iff (!reset_n) // R12
		rgbCapture |=> r_reg.word.red == $past(pixelBus[4:0])
		&& r_reg.word.blue == $past(pixelBus[15:11])) else $error("RGB lanes wrong");
	// R11 half-rate words
	chk_half_rate: assert property (@(posedge clock) disable iff (!reset_n) // R11
		r_reg.pushValid && wideFmt && $past(wideFmt) |=> !r_reg.pushValid)
		else $error("Wide word pushed on consecutive clocks");
	// R5 one word per luma-chroma pair
	chk_ddr_pair: assert property (@(posedge clock) disable iff (!reset_n) // R5
		r_reg.pushValid && !wideFmt |-> $past(r_reg.state) == ST_SECOND)
		else $error("Pair word without two phases");
endmodule

/* File: pixel_port_cfg.svh */
// What this block does
// R1 - Three-bit input mode picks SD, ED/HD DDR or ED doubled-rate capture.
// R2 - Input mode resets to standard definition until software changes it.
// R3 - Narrow SD: interleaved 8-bit YCrCb, bit 0 LSB, 27 MHz clock.
// R4 - SD and DDR modes take timing from external syncs or embedded codes.
// R5 - DDR mode: luma on one clock edge, chroma on the other, same lines; code takes both from the selected edge on alternate clocks.
// R6 - Two-bit edge field picks the clock edge that carries luma in DDR.
// R7 - Doubled-rate ED: 54 MHz, embedded codes only, external syncs ignored.
// R8 - Wide SD: source drives a 27 MHz clock for every format.
// R9 - Width 00, no RGB: 8-bit YCrCb on the upper eight lines.
// R10 - Width 10: 10-bit YCrCb on upper ten lines, line 6 LSB.
// R11 - Width 01: luma upper byte, chroma lower byte, words every second clock.
// R12 - RGB on: red 4..0, green 10..5, blue 15..11, half clock rate.
// R13 - Wide SD 16-bit formats need external syncs; embedded codes not honoured.
// R14 - Smallest package variant supports only standard definition mode.
// R15 - Width code 11 is reserved; no capture is defined for it.
// R16 - Single-edge modes register data and syncs on one clock edge.
`ifndef PIXEL_PORT_CFG_SVH
`define PIXEL_PORT_CFG_SVH
`define MODE_SD 3'h0
`define MODE_DDR 3'h2
`define MODE_ED54 3'h7
`define MODE_RESET 3'h0
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_10 2'h2
`define WIDTH_RSVD 2'h3
`define EDGE_LUMA_FALL 2'h3
`define EAV_BIT 4
`define FIFO_DEPTH 8
`endif

/* File: pixel_port_pkg.sv */
package pixel_port_pkg;
	typedef struct packed {
		logic [9:0] luma;
		logic [9:0] chroma;
		logic [4:0] red;
		logic [5:0] green;
		logic [4:0] blue;
		logic isRgb;
		logic hsync;
		logic vsync;
		logic timingEmbedded;
		logic codeSeen;
	} pixel_word_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FIRST = 4'h2,
		ST_SECOND = 4'h4,
		ST_HOLD = 4'h8
	} cap_state_t;
	typedef struct packed {
		cap_state_t state;
		logic [9:0] firstByte;
		logic [2:0] codeRun;
		logic pushValid;
		pixel_word_t word;
	} cap_regs_t;
endpackage

/* File: pixel_fifo.sv */
`timescale 1ns/10ps
module pixel_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	logic doPush;
	logic doPop;
	assign inReady = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;
	assign outData = mem_reg[rdPtr_reg];
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (doPush) begin
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (doPop) begin
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
			end
			if (doPush && !doPop) begin
				count_reg <= count_reg + 1'b1;
			end else if (doPop && !doPush) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (doPush) begin
			mem_reg[wrPtr_reg] <= inData;
		end
	end
endmodule

/* File: video_source.sv */
`timescale 1ns/10ps
module video_source (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [15:0] firstWord,
	input wire logic [15:0] secondWord,
	input wire logic syncLow,
	output logic [15:0] pixelBus,
	output logic hsync_n,
	output logic vsync_n
);
	logic phase;
	// stream advances on every rising clock edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			// Starts on the chroma lane so the first luma meets the first capture edge
			phase <= 1'b1;
		end else begin
			phase <= ~phase;
		end
	end
	// luma lane first, chroma lane second
	assign pixelBus = phase ? secondWord : firstWord;
	// external syncs driven by the source
	assign hsync_n = ~syncLow;
	assign vsync_n = 1'b1;
endmodule

/* File: tb.sv */
`timescale 1ns/10ps
`include "pixel_port_cfg.svh"
module tb;
	import pixel_port_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] pixelBus, firstWord = 16'h0, secondWord = 16'h0;
	logic hsync_n, vsync_n, inputModeLoad = 1'b0, rgbCaptureSelect = 1'b0;
	logic [2:0] inputModeWrite = 3'h0, inputMode;
	logic [1:0] ddrEdgeSelect = 2'h0, sdBusWidthSelect = 2'h0;
	logic embeddedTimingSelect = 1'b1, pixelReady = 1'b1, syncLow = 1'b0;
	logic formatReserved, overflow, pixelValid;
	pixel_word_t pixelWord, w;
	int failures = 0, samples_checked = 0, cycles = 0, n;
	always #50 clock = ~clock;
	video_source src (.clock(clock), .reset_n(reset_n), .firstWord(firstWord),
		.secondWord(secondWord), .syncLow(syncLow), .pixelBus(pixelBus),
		.hsync_n(hsync_n), .vsync_n(vsync_n));
	video_pixel_input_port uut (.clock(clock), .reset_n(reset_n), .pixelBus(pixelBus),
		.hsync_n(hsync_n), .vsync_n(vsync_n), .inputModeWrite(inputModeWrite),
		.inputModeLoad(inputModeLoad), .ddrEdgeSelect(ddrEdgeSelect),
		.sdBusWidthSelect(sdBusWidthSelect), .rgbCaptureSelect(rgbCaptureSelect),
		.embeddedTimingSelect(embeddedTimingSelect), .inputMode(inputMode),
		.formatReserved(formatReserved), .overflow(overflow), .pixelValid(pixelValid),
		.pixelReady(pixelReady), .pixelWord(pixelWord));
	task automatic tally_and_finish;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic restart(input logic [1:0] wd, input logic rgb, input logic emb,
		input logic [15:0] a, input logic [15:0] b);
		@(posedge clock);
		reset_n <= 1'b0;
		sdBusWidthSelect <= wd;
		rgbCaptureSelect <= rgb;
		embeddedTimingSelect <= emb;
		firstWord <= a;
		secondWord <= b;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
	endtask
	task automatic get_word(input int cnt);
		int got;
		int guard;
		got = 0;
		guard = 0;
		while (got < cnt && guard < 200) begin
			@(posedge clock);
			guard++;
			if (pixelValid === 1'b1 && pixelReady === 1'b1) begin
				w = pixelWord;
				got++;
			end
		end
		check(16'(got), 16'(cnt));
	endtask
	task automatic load_mode(input logic [2:0] m);
		@(posedge clock);
		inputModeWrite <= m;
		inputModeLoad <= 1'b1;
		@(posedge clock);
		inputModeLoad <= 1'b0;
		@(posedge clock);
	endtask
	task automatic test_reset;
		check(inputMode, `MODE_RESET);
		check(overflow, 1'b0);
		$display("test reset done");
	endtask
	task automatic test_modes;
		logic [2:0] req [4] = '{3'h1, 3'h2, 3'h7, 3'h0};
		logic [2:0] exp [4] = '{3'h0, 3'h2, 3'h7, 3'h0};
		for (int i = 0; i < 4; i++) begin
			load_mode(req[i]);
			check(inputMode, exp[i]);
		end
		$display("test modes done");
	endtask
	task automatic test_sd_interleaved;
		restart(`WIDTH_8, 1'b0, 1'b1, 16'hc311, 16'h5a22);
		get_word(1);
		check(w.luma, {8'hc3, 2'b00});
		check(w.chroma, {8'h5a, 2'b00});
		check(w.timingEmbedded, 1'b1);
		restart(`WIDTH_10, 1'b0, 1'b1, 16'hb6c0, 16'h4a40);
		get_word(1);
		check(w.luma, 10'h2db);
		check(w.chroma, 10'h129);
		$display("test sd interleaved done");
	endtask
	task automatic test_sd_wide;
		syncLow <= 1'b1;
		restart(`WIDTH_16, 1'b0, 1'b1, 16'h9e27, 16'h9e27);
		get_word(2);
		check(w.luma, {8'h9e, 2'b00});
		check(w.chroma, {8'h27, 2'b00});
		check(w.timingEmbedded, 1'b0);
		check(w.hsync, 1'b0);
		restart(`WIDTH_10, 1'b1, 1'b0, 16'hd35b, 16'hd35b);
		get_word(2);
		check(w.red, 5'h1b);
		check(w.green, 6'h1a);
		check(w.blue, 5'h1a);
		check(w.isRgb, 1'b1);
		check(w.hsync, 1'b0);
		syncLow <= 1'b0;
		$display("test sd wide done");
	endtask
	task automatic test_ddr_ed;
		for (int e = 0; e < 4; e = e + 3) begin
			restart(`WIDTH_8, 1'b0, 1'b0, 16'h7f80, 16'h7f80);
			ddrEdgeSelect <= e[1:0];
			load_mode(`MODE_DDR);
			get_word(3);
			check(w.luma, 10'h1fe);
			check(w.chroma, 10'h1fe);
		end
		syncLow <= 1'b1;
		load_mode(`MODE_ED54);
		get_word(3);
		check(w.timingEmbedded, 1'b1);
		check(w.hsync, 1'b1);
		syncLow <= 1'b0;
		$display("test ddr ed done");
	endtask
	task automatic test_fill_reserved;
		pixelReady <= 1'b0;
		restart(`WIDTH_8, 1'b0, 1'b1, 16'h1234, 16'h5678);
		repeat (60) @(posedge clock);
		check(pixelValid, 1'b1);
		sdBusWidthSelect <= `WIDTH_RSVD;
		@(posedge clock);
		@(posedge clock);
		check(formatReserved, 1'b1);
		pixelReady <= 1'b1;
		n = 0;
		repeat (40) begin
			@(posedge clock);
			if (pixelValid === 1'b1) n++;
		end
		check(16'(n), 16'(`FIFO_DEPTH));
		$display("test fill reserved done");
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		test_reset();
		test_modes();
		test_sd_interleaved();
		test_sd_wide();
		test_ddr_ed();
		test_fill_reserved();
		tally_and_finish();
	end
endmodule
